// ===== src/ladder_defs.svh
/*
  Constants of the ladder census / last-position command logic.
  Assumes inclusion by bare name from the design files.
*/
`ifndef LADDER_DEFS_SVH
`define LADDER_DEFS_SVH

// ****************************************
// Addresses and command codes
// ****************************************
`define LDR_BCAST_ADDR 7'h30
`define LDR_POS_REG_CMD 8'h01
`define LDR_ADDR_MSBS 2'h2
`define LDR_DIR_READ 1'h1

// ****************************************
// Stream values
// ****************************************
`define LDR_IDLE_BYTE 8'hFF
`define LDR_CHECK_BYTE 8'h00
`define LDR_CRC_POLY 8'h07
`define LDR_CRC_INIT 8'h00

// ****************************************
// Byte and bit positions within frames
// ****************************************
`define LDR_IDX_CMD 3'h1
`define LDR_IDX_DATA_HI 3'h3
`define LDR_IDX_PEC 3'h4
`define LDR_TX_HIGH 3'h1
`define LDR_TX_CHECK 3'h2
`define LDR_TX_PEC 3'h3
`define LDR_BIT_ACK 4'h8
`define LDR_BIT_LAST 4'h7

// ****************************************
// Reset value and sizes
// ****************************************
`define LDR_LAST_POS_RST 5'h00
`define LDR_FIFO_DEPTH 8
`define LDR_BYTE_W 8

`endif

// ===== src/ladder_pkg.sv
/*
  Types shared by the ladder command logic.
  Assumes ladder_defs.svh is on the include path.
*/
`include "ladder_defs.svh"

package ladder_pkg;

  // ****************************************
  // Link phase
  // ****************************************
  typedef enum logic [4:0] {
    PH_IDLE = 5'b00001,
    PH_ADDR = 5'b00010,
    PH_WRITE = 5'b00100,
    PH_READ = 5'b01000,
    PH_SKIP = 5'b10000
  } phase_e;

  typedef logic [7:0] byte_t;

  // Bitwise CRC-8 step over one byte, MSB first
  function automatic byte_t crc8_step(input byte_t crc, input byte_t data);
    byte_t c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ `LDR_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

endpackage

// ===== src/ladder_fifo.sv
/*
  Byte FIFO for bytes arriving from the device above in the ladder.
  Assumes a single clock; flush empties it in one cycle.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ladder_defs.svh"

module ladder_fifo #(
  parameter int WIDTH = `LDR_BYTE_W,
  parameter int DEPTH = `LDR_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
      $error("ladder_fifo: DEPTH must be a power of two >= 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready_o = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
  assign out_valid_o = wr_ptr != rd_ptr;
  assign out_data_o = mem[rd_ptr[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // ****************************************
  // Storage, one flop row per entry
  // ****************************************
  genvar e;
  generate
    for (e = 0; e < DEPTH; e++) begin : g_entry
      always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
          mem[e] <= '0;
        end else if (push && wr_ptr[AW-1:0] == AW'(e)) begin
          mem[e] <= in_data_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || flush_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= wr_ptr + (AW+1)'(push);
      rd_ptr <= rd_ptr + (AW+1)'(pop);
    end
  end

endmodule

`default_nettype wire

// ===== src/ladder_census_last_position.sv
/*
  Ladder port command logic: census read and set-last-position,
  with command relay up the ladder and byte forwarding down it.
  Assumes the downstream clock/data and upstream data pins are
  asynchronous to sys_clk_i and slow (8+ samples per link period);
  own_position_i comes from same-clock logic.
*/
// Functional notes
// - Relay every command byte up ladder.
// - Return own position byte, then last position byte.
// - Then forward bytes from device above.
// - Without data, forward idle 0xFF bytes.
// - Propagate stop up, ending transfer.
// - Buffer upstream bytes, hiding forwarding delay.
// - Position byte encoded, bits reversed.
// - Store last position, place checksum byte.
// - Set-last writes five-bit last-position field.
// - All data bytes go MSB first.
// - Store second data byte only, checked.
// - Address byte is 10 then position.
`timescale 1ns/10ps
`default_nettype none
`include "ladder_defs.svh"

module ladder_census_last_position
  import ladder_pkg::*;
#(
  parameter logic [6:0] BCAST_ADDR = `LDR_BCAST_ADDR,
  parameter int FIFO_DEPTH = `LDR_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Own position from assignment logic
  input wire logic [4:0] own_position_i,
  // Downstream link, toward the host
  input wire logic dn_scl_i,
  input wire logic dn_sda_i,
  output logic dn_sda_o,
  output logic dn_sda_oe_o,
  // Upstream link, toward the next device
  output logic up_scl_o,
  input wire logic up_sda_i,
  output logic up_sda_o,
  output logic up_sda_oe_o,
  // Status
  output logic [4:0] last_position_o,
  output logic census_active_o
);

  // ****************************************
  // Pin synchronisers and edge detection
  // ****************************************
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] up_sync;
  logic scl_d;
  logic sda_d;

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      up_sync <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], dn_scl_i};
      sda_sync <= {sda_sync[0], dn_sda_i};
      up_sync <= {up_sync[0], up_sda_i};
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_s = scl_sync[1];
  assign sda_s = sda_sync[1];
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_det = scl_s && scl_d && sda_d && !sda_s;
  assign stop_det = scl_s && scl_d && !sda_d && sda_s;

  // ****************************************
  // Bit and byte framing
  // ****************************************
  phase_e phase;
  logic [3:0] bit_cnt;
  logic [2:0] byte_idx;
  byte_t rx_shift;
  byte_t rx_byte;
  logic byte_end;
  logic census_armed;
  logic [4:0] last_pos;
  logic [4:0] last_pend;
  logic last_ok;
  byte_t rx_crc;

  assign rx_byte = {rx_shift[6:0], sda_s};
  assign byte_end = scl_rise && bit_cnt == `LDR_BIT_LAST;

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || start_det || stop_det) begin
      bit_cnt <= 4'h0;
    end else if (scl_rise) begin
      bit_cnt <= (bit_cnt == `LDR_BIT_ACK) ? 4'h0 : bit_cnt + 4'h1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      rx_shift <= 8'h00;
    end else if (scl_rise && bit_cnt < `LDR_BIT_ACK) begin
      rx_shift <= rx_byte;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || start_det) begin
      byte_idx <= 3'h0;
    end else if (byte_end && byte_idx != 3'h7) begin
      byte_idx <= byte_idx + 3'h1;
    end
  end

  // ****************************************
  // Phase control
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      phase <= PH_IDLE;
    end else if (stop_det) begin
      // stop ends the transfer here too
      phase <= PH_IDLE;
    end else if (start_det) begin
      phase <= PH_ADDR;
    end else if (byte_end && phase == PH_ADDR) begin
      if (rx_byte[7:1] != BCAST_ADDR) begin
        phase <= PH_SKIP;
      end else if (rx_byte[0] != `LDR_DIR_READ) begin
        phase <= PH_WRITE;
      end else if (census_armed) begin
        phase <= PH_READ;
      end else begin
        phase <= PH_SKIP;
      end
    end else if (scl_rise && bit_cnt == `LDR_BIT_ACK && phase == PH_READ && sda_s) begin
      // Host not-acknowledge: stop reading, wait for stop
      phase <= PH_SKIP;
    end
  end

  // Census only answers a read that followed command 0x01
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || stop_det) begin
      census_armed <= 1'b0;
    end else if (byte_end && phase == PH_WRITE && byte_idx == `LDR_IDX_CMD) begin
      census_armed <= rx_byte == `LDR_POS_REG_CMD;
    end
  end

  // ****************************************
  // Set-last-position write path
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || start_det) begin
      rx_crc <= `LDR_CRC_INIT;
    end else if (byte_end && byte_idx < `LDR_IDX_PEC) begin
      rx_crc <= crc8_step(rx_crc, rx_byte);
    end
  end

  // keep second data byte, check PEC
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || start_det) begin
      last_pend <= `LDR_LAST_POS_RST;
      last_ok <= 1'b0;
    end else if (byte_end && phase == PH_WRITE && census_armed) begin
      if (byte_idx == `LDR_IDX_DATA_HI) begin
        last_pend <= rx_byte[4:0];
      end
      if (byte_idx == `LDR_IDX_PEC) begin
        last_ok <= rx_byte == rx_crc;
      end else begin
        last_ok <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      last_pos <= `LDR_LAST_POS_RST;
    end else if (stop_det && phase == PH_WRITE && last_ok) begin
      last_pos <= last_pend;
    end
  end

  // ****************************************
  // Upstream capture into the FIFO
  // ****************************************
  byte_t up_shift;
  logic up_push;
  logic fifo_valid;
  logic fifo_pop;
  byte_t fifo_data;

  // bytes from above queue while own bytes go out
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      up_shift <= 8'h00;
      up_push <= 1'b0;
    end else begin
      up_push <= 1'b0;
      if (phase == PH_READ && scl_rise && bit_cnt < `LDR_BIT_ACK) begin
        up_shift <= {up_shift[6:0], up_sync[1]};
        up_push <= bit_cnt == `LDR_BIT_LAST;
      end
    end
  end

  ladder_fifo #(
    .WIDTH(`LDR_BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .flush_i(start_det),
    .in_valid_i(up_push),
    .in_ready_o(),
    .in_data_i(up_shift),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data)
  );

  // ****************************************
  // Downstream byte selection
  // ****************************************
  logic [2:0] tx_cnt;
  byte_t tx_shift;
  byte_t tx_crc;
  byte_t next_tx;
  logic tx_load;
  logic is_last;

  assign tx_load = phase == PH_READ && scl_fall && bit_cnt == 4'h0;
  assign is_last = own_position_i == last_pos;
  // A full FIFO drops the byte: the far end outruns a stalled drain
  assign fifo_pop = tx_load && tx_cnt > `LDR_TX_HIGH && !is_last;

  always_comb begin
    next_tx = `LDR_IDLE_BYTE;
    if (tx_cnt == 3'h0) begin
      next_tx = {`LDR_ADDR_MSBS, own_position_i[0], own_position_i[1],
                 own_position_i[2], own_position_i[3], own_position_i[4], 1'b0};
    end else if (tx_cnt == `LDR_TX_HIGH) begin
      next_tx = {3'h0, last_pos};
    end else if (is_last) begin
      if (tx_cnt == `LDR_TX_CHECK) begin
        next_tx = `LDR_CHECK_BYTE;
      end else if (tx_cnt == `LDR_TX_PEC) begin
        next_tx = tx_crc;
      end
    end else if (fifo_valid) begin
      next_tx = fifo_data;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || start_det) begin
      tx_cnt <= 3'h0;
      tx_crc <= `LDR_CRC_INIT;
    end else if (tx_load) begin
      tx_cnt <= (tx_cnt == 3'h7) ? tx_cnt : tx_cnt + 3'h1;
      tx_crc <= crc8_step(tx_crc, next_tx);
    end
  end

  // ****************************************
  // Downstream open-drain drive
  // ****************************************
  logic ack_slot;
  logic ack_me;

  assign ack_slot = scl_fall && bit_cnt == `LDR_BIT_ACK;
  assign ack_me = phase == PH_WRITE || (phase == PH_READ && byte_idx == 3'h1);

  // drive MSB first, release at ack
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || stop_det || start_det) begin
      tx_shift <= `LDR_IDLE_BYTE;
      dn_sda_o <= 1'b1;
      dn_sda_oe_o <= 1'b0;
    end else if (tx_load) begin
      tx_shift <= {next_tx[6:0], 1'b1};
      dn_sda_o <= next_tx[7];
      dn_sda_oe_o <= !next_tx[7];
    end else if (phase == PH_READ && scl_fall && bit_cnt < `LDR_BIT_ACK) begin
      tx_shift <= {tx_shift[6:0], 1'b1};
      dn_sda_o <= tx_shift[7];
      dn_sda_oe_o <= !tx_shift[7];
    end else if (ack_slot && ack_me) begin
      dn_sda_o <= 1'b0;
      dn_sda_oe_o <= 1'b1;
    end else if (scl_fall) begin
      dn_sda_o <= 1'b1;
      dn_sda_oe_o <= 1'b0;
    end
  end

  // ****************************************
  // Upstream relay
  // ****************************************
  logic relay_en;

  // Read data bits come from above, so only the ack slot is relayed then
  assign relay_en = phase != PH_READ || bit_cnt == `LDR_BIT_ACK;

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      up_scl_o <= 1'b1;
      up_sda_o <= 1'b1;
      up_sda_oe_o <= 1'b0;
    end else begin
      up_scl_o <= scl_s;
      up_sda_o <= relay_en ? sda_s : 1'b1;
      up_sda_oe_o <= relay_en && !sda_s;
    end
  end

  // ****************************************
  // Status
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      last_position_o <= `LDR_LAST_POS_RST;
      census_active_o <= 1'b0;
    end else begin
      last_position_o <= last_pos;
      census_active_o <= phase == PH_READ;
    end
  end

endmodule

`default_nettype wire

// ===== sim/ladder_census_assertions.sv
/*
  Port checker for the ladder census / last-position logic.
  Assumes binding to the top module; one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module ladder_census_checker (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Link
  input wire logic dn_scl_i,
  input wire logic dn_sda_i,
  input wire logic dn_sda_oe_o,
  input wire logic up_scl_o,
  input wire logic up_sda_oe_o,
  // Status
  input wire logic [4:0] last_position_o,
  input wire logic census_active_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // ****
  // Properties
  // ****
  reset_quiet_a: assert property ($rose(rstn_i) |-> !dn_sda_oe_o && up_scl_o && !census_active_o && last_position_o == 5'h00)
    else $error("outputs not idle after reset");
  scl_rise_a: assert property ($rose(dn_scl_i) |-> ##[1:5] up_scl_o)
    else $error("serial clock rise not relayed");
  scl_fall_a: assert property ($fell(dn_scl_i) |-> ##[1:5] !up_scl_o)
    else $error("serial clock fall not relayed");
  sda_mirror_a: assert property (!census_active_o && !dn_sda_oe_o
    && !$past(dn_sda_oe_o) && $fell(dn_sda_i) |-> ##[1:5] up_sda_oe_o)
    else $error("low data not relayed up");
  stop_up_a: assert property (dn_scl_i && $rose(dn_sda_i) |-> ##[1:6] (!up_sda_oe_o && up_scl_o))
    else $error("stop not relayed up");
  stop_ends_a: assert property (dn_scl_i && $rose(dn_sda_i) |-> ##[1:6] !census_active_o)
    else $error("census still active after stop");
  drive_low_a: assert property ($rose(dn_sda_oe_o) |-> !dn_scl_i)
    else $error("data driven while clock high");
  last_commit_a: assert property ($changed(last_position_o) |-> dn_scl_i && dn_sda_i)
    else $error("last position changed outside stop");
endmodule
bind ladder_census_last_position ladder_census_checker u_chk (.sys_clk_i(sys_clk_i),
  .rstn_i(rstn_i), .dn_scl_i(dn_scl_i), .dn_sda_i(dn_sda_i), .dn_sda_oe_o(dn_sda_oe_o),
  .up_scl_o(up_scl_o), .up_sda_oe_o(up_sda_oe_o), .last_position_o(last_position_o),
  .census_active_o(census_active_o));
`default_nettype wire

// ===== sim/ladder_upper_model.sv
/*
  Device slot above the block: an open-drain data line with pull-up.
  Assumes the bench sets powered_i; an unpowered slot holds the line low.
*/
`timescale 1ns/10ps
`default_nettype none
module ladder_upper_model (
  // Control
  input wire logic powered_i,
  // Link
  input wire logic up_sda_oe_o,
  output logic up_sda_i
);
  assign up_sda_i = powered_i & !up_sda_oe_o;
endmodule
`default_nettype wire

// ===== sim/ladder_census_last_position_tb_top.sv
/*
  Bench for the ladder census / last-position logic, acting as host.
  Assumes the design package and the upper-slot model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module ladder_census_last_position_tb_top;
  logic sys_clk_i = 0;
  logic rstn_i = 0;
  logic dn_scl_i = 1;
  logic host_sda = 1;
  logic powered = 1;
  logic [4:0] own_position_i = 5'h01;
  logic dn_sda_i, dn_sda_o, dn_sda_oe_o, up_scl_o, up_sda_i, up_sda_o, up_sda_oe_o;
  logic census_active_o;
  logic [4:0] last_position_o;
  int n_errors = 0;
  int tests_run = 0;
  // Open-drain wire: host and device both pull
  assign dn_sda_i = host_sda & !dn_sda_oe_o;
  always #50 sys_clk_i = ~sys_clk_i;
  ladder_census_last_position dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .own_position_i(own_position_i), .dn_scl_i(dn_scl_i), .dn_sda_i(dn_sda_i),
    .dn_sda_o(dn_sda_o), .dn_sda_oe_o(dn_sda_oe_o), .up_scl_o(up_scl_o),
    .up_sda_i(up_sda_i), .up_sda_o(up_sda_o), .up_sda_oe_o(up_sda_oe_o),
    .last_position_o(last_position_o), .census_active_o(census_active_o));
  ladder_upper_model upper (.powered_i(powered), .up_sda_oe_o(up_sda_oe_o),
    .up_sda_i(up_sda_i));
  // ****
  // Host tasks
  // ****
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  // One 800 ns bit; sampled late in the high phase
  task automatic sbit(input logic b, output logic r);
    dn_scl_i = 0;
    cyc(2);
    host_sda = b;
    cyc(2);
    dn_scl_i = 1;
    cyc(4);
    r = dn_sda_i;
  endtask
  task automatic start();
    logic r;
    sbit(1'b1, r);
    host_sda = 0;
    cyc(4);
  endtask
  task automatic stop();
    logic r;
    sbit(1'b0, r);
    host_sda = 1;
    cyc(8);
  endtask
  task automatic wbyte(input logic [7:0] b, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) sbit(b[i], r);
    sbit(1'b1, r);
    check({7'h0, r}, {7'h0, ack}); // acknowledge
  endtask
  task automatic rbyte(output logic [7:0] b, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) sbit(1'b1, b[i]);
    sbit(!ack, r);
  endtask
  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    repeat (8) x = x[7] ? ({x[6:0], 1'b0} ^ 8'h07) : {x[6:0], 1'b0};
    return x;
  endfunction
  // ****
  // Scenarios
  // ****
  task automatic set_last(input logic [4:0] lp, input logic good, input logic [4:0] exp);
    logic [7:0] c;
    c = crc(crc(crc(crc(8'h00, 8'h60), 8'h01), 8'h5A), {3'h0, lp});
    start();
    wbyte(8'h60, 1'b0);
    wbyte(8'h01, 1'b0);
    wbyte(8'h5A, 1'b0);
    wbyte({3'h0, lp}, 1'b0);
    wbyte(good ? c : ~c, 1'b0);
    stop();
    check({3'h0, last_position_o}, {3'h0, exp});
  endtask
  // Census: own bytes, then n more bytes, host NACKs the last
  task automatic census(input logic [4:0] p, input logic [7:0] hi, e2, e3, e4,
    input int n);
    logic [7:0] r;
    own_position_i = p;
    // broadcast write, command, repeated start, read
    start();
    wbyte(8'h60, 1'b0);
    wbyte(8'h01, 1'b0);
    start();
    wbyte(8'h61, 1'b0);
    rbyte(r, 1'b1);
    check(r, {2'b10, p[0], p[1], p[2], p[3], p[4], 1'b0});
    check({7'h0, census_active_o}, 8'h01);
    // host decides nothing on the high byte
    rbyte(r, 1'b1);
    check(r, hi);
    rbyte(r, 1'b1);
    check(r, e2);
    // NACK on second idle byte or on the PEC when n is 2, else on the third forwarded byte
    rbyte(r, n > 2);
    check(r, e3);
    if (n > 2) begin
      rbyte(r, 1'b0);
      check(r, e4);
    end
    stop();
    check({7'h0, census_active_o}, 8'h00);
  endtask
  task automatic bad_address();
    start();
    wbyte(8'h42, 1'b1);
    stop();
    check({3'h0, last_position_o}, 8'h03);
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #2000000;
    n_errors++;
    close_out();
  end
  initial begin
    logic [7:0] pec;
    cyc(4);
    rstn_i = 1;
    cyc(4);
    check({dn_sda_oe_o, census_active_o, 1'b0, last_position_o}, 8'h00);
    check({dn_sda_o, up_scl_o, up_sda_o, up_sda_oe_o, 4'h0}, 8'hE0);
    census(5'h01, 8'h00, 8'hFF, 8'hFF, 8'hFF, 2);
    set_last(5'h03, 1'b1, 5'h03);
    set_last(5'h07, 1'b0, 5'h03);
    census(5'h01, 8'h03, 8'hFF, 8'hFF, 8'hFF, 2);
    powered = 0;
    census(5'h02, 8'h03, 8'h00, 8'h00, 8'h00, 3);
    powered = 1;
    pec = crc(crc(crc(8'h00, 8'hB0), 8'h03), 8'h00);
    census(5'h03, 8'h03, 8'h00, pec, 8'hFF, 2);
    bad_address();
    close_out();
  end
endmodule
`default_nettype wire
